// ==== hw/msr_scene_ctrl.sv ====
// Purpose: MIDI message layer: channel filter, scene recall table, echo, bulk sequencing
// Assumes: Byte streams in and out, one clock, synchronous reset
// Notes:   Bulk payload content is produced elsewhere; frames here carry only the header
`timescale 1ns/1ps
`default_nettype none
`include "msr_params.svh"
module msr_scene_ctrl #(
  parameter int          FIFO_DEPTH = `MSR_FIFO_DEPTH,
  parameter logic [7:0]  ITEM_COUNT = `MSR_ITEM_COUNT
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                rxValid,
  input  wire logic [7:0]          rxData,
  output logic                     rxReady,
  output logic                     txValid,
  output logic      [7:0]          txData,
  input  wire logic                txReady,
  input  wire logic [3:0]          rxChannel,
  input  wire logic                rxPgmEn,
  input  wire logic                rxParEn,
  input  wire logic                rxCtlEn,
  input  wire logic                txPgmEn,
  input  wire logic                txParEn,
  input  wire logic                omniEn,
  input  wire logic                echoEn,
  input  wire logic                txChanWr,
  input  wire logic [3:0]          txChanIn,
  output logic      [3:0]          txChannel,
  output logic                     recallValid,
  output logic      [6:0]          recallScene,
  output logic                     ctlValid,
  output logic      [6:0]          ctlNum,
  output logic      [6:0]          ctlValue,
  output logic                     parRxValid,
  output logic      [7:0]          parRxByte,
  input  wire logic                txPgmReq,
  input  wire logic [6:0]          txPgmNum,
  input  wire logic                parOutValid,
  input  wire logic [7:0]          parOutByte,
  output logic                     parOutReady,
  input  wire logic                tblWr,
  input  wire logic [6:0]          tblAddr,
  input  wire logic [6:0]          tblScene,
  input  wire logic                tblEn,
  input  wire logic                tblReset,
  input  wire logic                tblUndo,
  output logic      [7:0]          tblRdData,
  input  wire logic                bulkGo,
  input  wire msr_pkg::msr_bcmd_e  bulkCmd,
  input  wire msr_pkg::msr_cat_e   bulkCat,
  input  wire logic [7:0]          bulkItem,
  input  wire logic                bulkAbort,
  output msr_pkg::msr_bulk_e       bulkStatus,
  output logic      [7:0]          bulkItemNow
);
  import msr_pkg::*;

  // Entry is {enable, scene}
  function automatic logic [7:0] defaultEntry(input logic [6:0] idx);
    if (idx <= `MSR_DEF_LAST)
      defaultEntry = {1'b1, idx + 7'h01};
    else if (idx == `MSR_DEF_INIT_PGM)
      defaultEntry = {1'b1, `MSR_INIT_SCENE};
    else
      defaultEntry = 8'h00;
  endfunction

  logic       byteValid;
  logic [7:0] byteData;
  logic       take;
  logic       isStatus;
  logic       isRealtime;
  logic       pcDone;
  logic [7:0] entry;
  logic [7:0] selEntry;
  msr_parse_e psState_ff;
  logic       pgmAccept_ff;
  logic [3:0] pgmChan_ff;
  logic [3:0] rxChanPrev_ff;
  logic       echoPend_ff;
  logic [7:0] echoMsg_ff [0:1];
  logic       pgmPend_ff;
  logic [6:0] pgmNum_ff;
  logic       parHold_ff;
  logic [7:0] parByte_ff;
  logic [7:0] msg_ff [0:4];
  logic [2:0] msgLen_ff;
  logic       txFree;
  logic       loadEcho;
  logic       loadPgm;
  logic       loadBulk;
  logic       loadPar;
  msr_bcmd_e  bCmd_ff;
  msr_cat_e   bCat_ff;
  logic [7:0] bLimit;
  logic [7:0] mapTbl_ff  [0:`MSR_TBL_DEPTH-1];
  logic [7:0] undoTbl_ff [0:`MSR_TBL_DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer; parser stalls while an echo waits, so the FIFO can fill
  msr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxFifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (rxValid),
    .inData   (rxData),
    .inReady  (rxReady),
    .outValid (byteValid),
    .outData  (byteData),
    .outReady (!echoPend_ff)
  );

  assign take       = byteValid && !echoPend_ff;
  assign isStatus   = byteData[7];
  assign isRealtime = (byteData[7:3] == 5'h1f);
  assign pcDone     = take && !isStatus && (psState_ff == MSR_P_PGM);
  assign entry      = mapTbl_ff[byteData[6:0]];
  assign selEntry   = mapTbl_ff[tblAddr];

  ////////////////////////////////////////////////////////////////////////////
  // Parser; realtime bytes are transparent and never disturb a message
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      psState_ff   <= MSR_P_IDLE;
      pgmAccept_ff <= 1'b0;
      pgmChan_ff   <= 4'h0;
    end
    else if (take && !isRealtime)
    begin
      if (isStatus)
      begin
        if (byteData[7:4] == `MSR_NIB_PGM)
        begin
          psState_ff   <= MSR_P_PGM;
          pgmChan_ff   <= byteData[3:0];
          pgmAccept_ff <= rxPgmEn && (omniEn || byteData[3:0] == rxChannel);
        end
        else if (byteData[7:4] == `MSR_NIB_CTL)
          psState_ff <= (rxCtlEn && byteData[3:0] == rxChannel) ?
                        MSR_P_CTL1 : MSR_P_SKIP;
        else if (byteData == `MSR_SYX_START)
          psState_ff <= rxParEn ? MSR_P_SMFR : MSR_P_SKIP;
        else
          psState_ff <= MSR_P_SKIP;
      end
      else
      begin
        case (psState_ff)
          MSR_P_PGM:   psState_ff <= MSR_P_IDLE;
          MSR_P_CTL1:  psState_ff <= MSR_P_CTL2;
          MSR_P_CTL2:  psState_ff <= MSR_P_IDLE;
          MSR_P_SMFR:  psState_ff <= MSR_P_SDEV;
          MSR_P_SDEV:  psState_ff <= (byteData[3:0] == rxChannel) ?
                                     MSR_P_SBODY : MSR_P_SKIP;
          MSR_P_SBODY: psState_ff <= MSR_P_SBODY;
          MSR_P_SKIP:  psState_ff <= MSR_P_SKIP;
          default:     psState_ff <= MSR_P_IDLE;
        endcase
      end
    end
  end

  // Received message outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      recallValid <= 1'b0;
      recallScene <= 7'h00;
      ctlValid    <= 1'b0;
      ctlNum      <= 7'h00;
      ctlValue    <= 7'h00;
      parRxValid  <= 1'b0;
      parRxByte   <= 8'h00;
    end
    else
    begin
      // Disabled or unassigned entry gives no recall
      recallValid <= pcDone && pgmAccept_ff && entry[7];
      if (pcDone)
        recallScene <= entry[6:0];
      ctlValid <= take && !isStatus && psState_ff == MSR_P_CTL2;
      if (take && !isStatus && psState_ff == MSR_P_CTL1)
        ctlNum <= byteData[6:0];
      if (take && !isStatus && psState_ff == MSR_P_CTL2)
        ctlValue <= byteData[6:0];
      parRxValid <= take && !isStatus && psState_ff == MSR_P_SBODY;
      if (take && !isStatus)
        parRxByte <= byteData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit channel follows every receive channel change
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rxChanPrev_ff <= 4'h0;
      txChannel     <= 4'h0;
    end
    else
    begin
      rxChanPrev_ff <= rxChannel;
      if (rxChannel != rxChanPrev_ff)
        txChannel <= rxChannel;
      else if (txChanWr)
        txChannel <= txChanIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mapping table with one saved copy for undo
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < `MSR_TBL_DEPTH; i++)
    begin
      if (rst)
      begin
        mapTbl_ff[i]  <= defaultEntry(7'(i));
        undoTbl_ff[i] <= defaultEntry(7'(i));
      end
      else if (tblReset)
      begin
        undoTbl_ff[i] <= mapTbl_ff[i];
        mapTbl_ff[i]  <= defaultEntry(7'(i));
      end
      else if (tblUndo)
        mapTbl_ff[i] <= undoTbl_ff[i];
      else if (tblWr)
      begin
        undoTbl_ff[i] <= mapTbl_ff[i];
        if (tblAddr == 7'(i))
          mapTbl_ff[i] <= {tblEn, tblScene};
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tblRdData <= 8'h00;
    else
      tblRdData <= selEntry;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sources, echo first so the receive path is released soonest
  assign txFree   = !txValid || txReady;
  assign loadEcho = (msgLen_ff == 3'h0) && echoPend_ff;
  assign loadPgm  = (msgLen_ff == 3'h0) && !echoPend_ff && pgmPend_ff;
  assign loadBulk = (msgLen_ff == 3'h0) && !echoPend_ff && !pgmPend_ff &&
                    (bulkStatus == MSR_B_SEND);
  assign loadPar  = (msgLen_ff == 3'h0) && !echoPend_ff && !pgmPend_ff &&
                    (bulkStatus != MSR_B_SEND) && parHold_ff;

  // Set wins over the clear taken by the loader
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      echoPend_ff   <= 1'b0;
      echoMsg_ff[0] <= 8'h00;
      echoMsg_ff[1] <= 8'h00;
      pgmPend_ff    <= 1'b0;
      pgmNum_ff     <= 7'h00;
      parHold_ff    <= 1'b0;
      parByte_ff    <= 8'h00;
      parOutReady   <= 1'b0;
    end
    else
    begin
      if (pcDone && echoEn)
      begin
        echoPend_ff   <= 1'b1;
        echoMsg_ff[0] <= {`MSR_NIB_PGM, pgmChan_ff};
        echoMsg_ff[1] <= byteData;
      end
      else if (loadEcho)
        echoPend_ff <= 1'b0;
      if (txPgmReq && txPgmEn)
      begin
        pgmPend_ff <= 1'b1;
        pgmNum_ff  <= txPgmNum;
      end
      else if (loadPgm)
        pgmPend_ff <= 1'b0;
      if (parOutValid && parOutReady)
      begin
        parHold_ff  <= txParEn;
        parByte_ff  <= parOutByte;
        parOutReady <= !txParEn;
      end
      else if (loadPar || !parHold_ff)
      begin
        parHold_ff  <= 1'b0;
        parOutReady <= 1'b1;
      end
    end
  end

  // Message buffer feeding the byte output
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      msgLen_ff <= 3'h0;
      txValid   <= 1'b0;
      txData    <= 8'h00;
      for (int k = 0; k < 5; k++)
        msg_ff[k] <= 8'h00;
    end
    else if (msgLen_ff != 3'h0)
    begin
      if (txFree)
      begin
        txValid   <= 1'b1;
        txData    <= msg_ff[0];
        msgLen_ff <= msgLen_ff - 3'h1;
        for (int k = 0; k < 4; k++)
          msg_ff[k] <= msg_ff[k+1];
      end
    end
    else
    begin
      if (txFree)
        txValid <= 1'b0;
      if (loadEcho)
      begin
        msg_ff[0] <= echoMsg_ff[0];
        msg_ff[1] <= echoMsg_ff[1];
        msgLen_ff <= 3'h2;
      end
      else if (loadPgm)
      begin
        msg_ff[0] <= {`MSR_NIB_PGM, txChannel};
        msg_ff[1] <= {1'b0, pgmNum_ff};
        msgLen_ff <= 3'h2;
      end
      else if (loadBulk)
      begin
        msg_ff[0] <= `MSR_SYX_START;
        msg_ff[1] <= `MSR_BULK_TAG | {6'h00, bCmd_ff};
        msg_ff[2] <= {5'h00, bCat_ff};
        msg_ff[3] <= bulkItemNow;
        msg_ff[4] <= `MSR_SYX_END;
        msgLen_ff <= 3'h5;
      end
      else if (loadPar)
      begin
        msg_ff[0] <= parByte_ff;
        msgLen_ff <= 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bulk sequencer; abort lets the frame in flight finish so the far end resyncs
  assign bLimit = (bCat_ff == MSR_K_SETUP || bCat_ff == MSR_K_TABLE) ?
                  8'h01 : ITEM_COUNT;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bulkStatus  <= MSR_B_IDLE;
      bulkItemNow <= 8'h00;
      bCmd_ff     <= MSR_C_DUMP;
      bCat_ff     <= MSR_K_SCENE;
    end
    else
    begin
      case (bulkStatus)
        MSR_B_SEND, MSR_B_WAIT:
        begin
          if (bulkAbort)
            bulkStatus <= MSR_B_ABORT;
          else if (bulkStatus == MSR_B_SEND && loadBulk)
            bulkStatus <= MSR_B_WAIT;
          else if (bulkStatus == MSR_B_WAIT && msgLen_ff == 3'h0)
          begin
            if (bCmd_ff[1] && (bulkItemNow + 8'h01) < bLimit)
            begin
              bulkItemNow <= bulkItemNow + 8'h01;
              bulkStatus  <= MSR_B_SEND;
            end
            else
              bulkStatus <= MSR_B_DONE;
          end
        end
        MSR_B_IDLE, MSR_B_DONE, MSR_B_ABORT:
        begin
          if (bulkGo)
          begin
            bCmd_ff     <= bulkCmd;
            bCat_ff     <= bulkCat;
            bulkStatus  <= MSR_B_SEND;
            bulkItemNow <= (bulkCmd[1] || bulkCat == MSR_K_SETUP ||
                            bulkCat == MSR_K_TABLE) ? 8'h00 : bulkItem;
          end
        end
        default: bulkStatus <= MSR_B_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_ctl_filter;
    (take && byteData[7:4] == `MSR_NIB_CTL && !rxCtlEn) |=> (psState_ff != MSR_P_CTL1);
  endproperty
  a_ctl_filter: assert property (p_ctl_filter) else $error("control accepted while off");

  property p_tx_follow;
    (rxChannel != rxChanPrev_ff) |=> (txChannel == $past(rxChannel));
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("tx channel did not follow");

  property p_pgm_gate;
    (txPgmReq && !txPgmEn && !pgmPend_ff) |=> !pgmPend_ff;
  endproperty
  a_pgm_gate: assert property (p_pgm_gate) else $error("program sent while disabled");

  property p_echo;
    (pcDone && echoEn) |=> echoPend_ff && (echoMsg_ff[1] == $past(byteData)) &&
                           (echoMsg_ff[0] == {`MSR_NIB_PGM, $past(pgmChan_ff)});
  endproperty
  a_echo: assert property (p_echo) else $error("program change not echoed");

  property p_recall;
    (pcDone && pgmAccept_ff && entry[7]) |=>
      recallValid && (recallScene == $past(entry[6:0]));
  endproperty
  a_recall: assert property (p_recall) else $error("recall scene wrong");

  property p_no_recall;
    (pcDone && !entry[7]) |=> !recallValid;
  endproperty
  a_no_recall: assert property (p_no_recall) else $error("recall from dead entry");

  property p_tbl_reset;
    tblReset |=> (mapTbl_ff[0] == 8'h81) && (mapTbl_ff[96] == 8'h80) &&
                 (mapTbl_ff[97] == 8'h00);
  endproperty
  a_tbl_reset: assert property (p_tbl_reset) else $error("table reset wrong");

  property p_undo_save;
    (tblWr && !tblReset && !tblUndo) |=> (undoTbl_ff[$past(tblAddr)] == $past(selEntry));
  endproperty
  a_undo_save: assert property (p_undo_save) else $error("undo copy not saved");

  property p_abort;
    (bulkAbort && (bulkStatus == MSR_B_SEND || bulkStatus == MSR_B_WAIT)) |=>
      (bulkStatus == MSR_B_ABORT);
  endproperty
  a_abort: assert property (p_abort) else $error("bulk not aborted");

  c_recall: cover property (recallValid);
  c_echo:   cover property (loadEcho);
  c_dumpall_done: cover property (bCmd_ff == MSR_C_DUMPALL && bulkStatus == MSR_B_DONE);
  c_undo:   cover property (tblWr ##[1:4] tblUndo);
endmodule
`default_nettype wire

// ==== shared/msr_params.svh ====
// Purpose: Constants for the MIDI scene recall and bulk control block
// Assumes: Included by bare name from design files
// Notes:   Byte values follow the MIDI wire format
`ifndef MSR_PARAMS_SVH
`define MSR_PARAMS_SVH

`define MSR_NIB_PGM      4'hc
`define MSR_NIB_CTL      4'hb
`define MSR_SYX_START    8'hf0
`define MSR_SYX_END      8'hf7
`define MSR_BULK_TAG     8'h20
`define MSR_TBL_DEPTH    128
`define MSR_DEF_LAST     7'h5f
`define MSR_DEF_INIT_PGM 7'h60
`define MSR_INIT_SCENE   7'h00
`define MSR_ITEM_COUNT   8'h60
`define MSR_FIFO_DEPTH   8

`endif

// ==== shared/msr_pkg.sv ====
// Purpose: Types shared by the MIDI scene recall and bulk control block
// Assumes: Nothing
// Notes:   Parser and bulk states are Gray coded along the usual path
`default_nettype none
package msr_pkg;

  typedef enum logic [2:0]
  {
    MSR_P_IDLE  = 3'h0,
    MSR_P_PGM   = 3'h1,
    MSR_P_CTL1  = 3'h3,
    MSR_P_CTL2  = 3'h2,
    MSR_P_SMFR  = 3'h6,
    MSR_P_SDEV  = 3'h7,
    MSR_P_SBODY = 3'h5,
    MSR_P_SKIP  = 3'h4
  } msr_parse_e;

  typedef enum logic [2:0]
  {
    MSR_B_IDLE  = 3'h0,
    MSR_B_SEND  = 3'h1,
    MSR_B_WAIT  = 3'h3,
    MSR_B_DONE  = 3'h2,
    MSR_B_ABORT = 3'h6
  } msr_bulk_e;

  typedef enum logic [1:0]
  {
    MSR_C_DUMP    = 2'h0,
    MSR_C_REQ     = 2'h1,
    MSR_C_DUMPALL = 2'h2,
    MSR_C_REQALL  = 2'h3
  } msr_bcmd_e;

  typedef enum logic [2:0]
  {
    MSR_K_SCENE  = 3'h0,
    MSR_K_AUTOMIX= 3'h1,
    MSR_K_CHLIB  = 3'h2,
    MSR_K_DYLIB  = 3'h3,
    MSR_K_EFLIB  = 3'h4,
    MSR_K_EQLIB  = 3'h5,
    MSR_K_SETUP  = 3'h6,
    MSR_K_TABLE  = 3'h7
  } msr_cat_e;

endpackage
`default_nettype wire

// ==== hw/msr_fifo.sv ====
// Purpose: Small FIFO between the MIDI receive stream and the parser
// Assumes: One clock, synchronous active-high reset
// Notes:   Read data and both ready/valid flags come from registers
`timescale 1ns/1ps
`default_nettype none
module msr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [CW-1:0]    count_ff;
  logic [CW-1:0]    nxt_count;
  logic             push;
  logic             pop;

  assign push = inValid && inReady;
  assign pop  = (count_ff != '0) && (!outValid || outReady);

  always_comb
  begin
    nxt_count = count_ff;
    if (push && !pop)
      nxt_count = count_ff + 1'b1;
    else if (pop && !push)
      nxt_count = count_ff - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wrPtr_ff] <= inData;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
      inReady  <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
      if (pop)
        rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
      count_ff <= nxt_count;
      // Registered full flag keeps back-pressure glitch free
      inReady  <= (nxt_count != CW'(DEPTH));
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      outValid <= 1'b0;
      outData  <= '0;
    end
    else if (pop)
    begin
      outValid <= 1'b1;
      outData  <= mem[rdPtr_ff];
    end
    else if (outReady)
      outValid <= 1'b0;
  end
endmodule
`default_nettype wire

// ==== bench/msr_far_end.sv ====
// Purpose: Far MIDI equipment model that takes the console output stream
// Assumes: One clock, synchronous active-high reset
// Notes:   Slow mode halves throughput so the sender must hold its byte
`timescale 1ns/1ps
`default_nettype none
module msr_far_end (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady
);
  logic [7:0] got[$];
  ////////////////////////////////////////
  // Ready toggles in slow mode, a real filer stalls like this
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      txReady <= 1'b0;
    else
      txReady <= slow ? ~txReady : 1'b1;
  end
  // Bytes of dumps, requests and program changes
  always @(posedge clk_sys)
  begin
    if (!rst && txValid && txReady)
      got.push_back(txData);
  end
endmodule
`default_nettype wire

// ==== bench/tb_msr_scene_ctrl.sv ====
// Purpose: Self-checking bench for the MIDI scene recall block
// Assumes: Inputs change on the falling edge
// Notes:   ITEM_COUNT cut to 3 so the all-item dumps stay short
`timescale 1ns/1ps
`default_nettype none
module tb_msr_scene_ctrl;
  import msr_pkg::*;
  logic clk_sys = 0, rst = 1, rxValid = 0, slow = 0, rxReady, txValid, txReady;
  logic rxPgmEn = 1, rxParEn = 1, rxCtlEn = 1, txPgmEn = 1, txParEn = 1;
  logic omniEn = 0, echoEn = 0, txPgmReq = 0, tblWr = 0, tblEn = 0, tblReset = 0;
  logic tblUndo = 0, bulkGo = 0, bulkAbort = 0;
  logic recallValid, ctlValid, parRxValid, parOutReady;
  logic [7:0] rxData = 0, bulkItem = 0, txData, tblRdData, bulkItemNow, parRxByte;
  logic [3:0] rxChannel = 0, txChannel;
  logic [6:0] txPgmNum = 0, tblAddr = 0, tblScene = 0, recallScene, ctlNum, ctlValue;
  msr_bcmd_e  bulkCmd = MSR_C_DUMP;
  msr_cat_e   bulkCat = MSR_K_SCENE;
  msr_bulk_e  bulkStatus;
  int         mismatches = 0, n_tests = 0;
  logic       parOutValid = 0;
  logic [7:0] parOutByte = 0;
  int         nCtl = 0, nPar = 0;

  always #5 clk_sys = ~clk_sys;

  msr_scene_ctrl #(.FIFO_DEPTH(8), .ITEM_COUNT(8'h03)) uut (
    .clk_sys, .rst, .rxValid, .rxData, .rxReady, .txValid, .txData, .txReady,
    .rxChannel, .rxPgmEn, .rxParEn, .rxCtlEn, .txPgmEn, .txParEn, .omniEn, .echoEn,
    .txChanWr(1'b0), .txChanIn(4'h0), .txChannel, .recallValid, .recallScene,
    .ctlValid, .ctlNum, .ctlValue, .parRxValid, .parRxByte, .txPgmReq, .txPgmNum,
    .parOutValid, .parOutByte, .parOutReady, .tblWr, .tblAddr,
    .tblScene, .tblEn, .tblReset, .tblUndo, .tblRdData, .bulkGo, .bulkCmd,
    .bulkCat, .bulkItem, .bulkAbort, .bulkStatus, .bulkItemNow);

  msr_far_end far (.clk_sys, .rst, .slow, .txValid, .txData, .txReady);

  // Pulse outputs counted where they stand
  always @(negedge clk_sys)
  begin
    if (ctlValid === 1'b1)
      nCtl++;
    if (parRxValid === 1'b1)
      nPar++;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task conclude;
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Holds the byte until the FIFO has room; caller drops valid after
  task automatic snd(input logic [7:0] b);
    int i;
    rxValid = 1;
    rxData = b;
    i = 0;
    while (rxReady !== 1'b1 && i < 99)
    begin
      @(negedge clk_sys);
      i++;
    end
    if (rxReady !== 1'b1)
    begin
      mismatches++;
      conclude;
    end
    @(negedge clk_sys);
  endtask

  task automatic msg3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    snd(a);
    snd(b);
    snd(c);
    rxValid = 0;
    repeat (12) @(negedge clk_sys);
  endtask

  // Holds the byte until the block takes it
  task automatic pout(input logic [7:0] b);
    int i;
    parOutValid = 1;
    parOutByte = b;
    i = 0;
    while (parOutReady !== 1'b1 && i < 99)
    begin
      @(negedge clk_sys);
      i++;
    end
    if (parOutReady !== 1'b1)
    begin
      mismatches++;
      conclude;
    end
    @(negedge clk_sys);
    parOutValid = 0;
  endtask

  task automatic pc(input logic [3:0] ch, input logic [6:0] p, input logic hit,
                    input logic [6:0] sc);
    logic       got;
    logic [6:0] s;
    got = 0;
    s = 0;
    snd({4'hc, ch});
    snd({1'b0, p});
    rxValid = 0;
    rxData = ~rxData;
    repeat (20)
    begin
      @(negedge clk_sys);
      if (recallValid === 1'b1)
      begin
        got = 1;
        s = recallScene;
      end
    end
    chk({7'h0, got}, {7'h0, hit});
    if (hit)
      chk({1'b0, s}, {1'b0, sc});
  endtask

  task automatic txq(input logic [7:0] e[$]);
    int i;
    i = 0;
    while (far.got.size() < e.size() && i < 300)
    begin
      @(negedge clk_sys);
      i++;
    end
    if (far.got.size() < e.size())
    begin
      mismatches++;
      conclude;
    end
    foreach (e[k])
      chk(far.got.size() > 0 ? far.got.pop_front() : 8'hxx, e[k]);
  endtask

  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk_sys);
    s = 0;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic wst(input msr_bulk_e e);
    int i;
    i = 0;
    while (bulkStatus !== e && i < 99)
    begin
      @(negedge clk_sys);
      i++;
    end
    if (bulkStatus !== e)
    begin
      mismatches++;
      conclude;
    end
    chk(8'(bulkStatus), 8'(e));
  endtask
  ////////////////////////////////////////
  task t_recall;
    pc(4'h0, 7'h04, 1, 7'h05);
    pc(4'h0, 7'h5f, 1, 7'h60);
    pc(4'h0, 7'h60, 1, 7'h00);
    pc(4'h0, 7'h61, 0, 7'h00);
    pc(4'h0, 7'h7f, 0, 7'h00);
    pc(4'h2, 7'h03, 0, 7'h00);
    omniEn = 1;
    pc(4'h2, 7'h03, 1, 7'h04);
    omniEn = 0;
    rxPgmEn = 0;
    pc(4'h0, 7'h03, 0, 7'h00);
    rxPgmEn = 1;
    $display("test recall done");
  endtask

  task t_chan;
    rxChannel = 4'h3;
    repeat (3) @(negedge clk_sys);
    chk({4'h0, txChannel}, 8'h03);
    txPgmNum = 7'h07;
    pulse(txPgmReq);
    txq('{8'hc3, 8'h07});
    txPgmEn = 0;
    pulse(txPgmReq);
    repeat (30) @(negedge clk_sys);
    chk(8'(far.got.size()), 8'h00);
    txPgmEn = 1;
    echoEn = 1;
    slow = 1;
    pc(4'h5, 7'h0a, 0, 7'h00);
    txq('{8'hc5, 8'h0a});
    echoEn = 0;
    slow = 0;
    $display("test channel done");
  endtask

  task t_ctl;
    int n0;
    n0 = nCtl;
    msg3(8'hb3, 8'h07, 8'h40);
    chk(8'(nCtl - n0), 8'h01);
    chk({1'b0, ctlNum}, 8'h07);
    chk({1'b0, ctlValue}, 8'h40);
    rxCtlEn = 0;
    msg3(8'hb3, 8'h08, 8'h41);
    chk(8'(nCtl - n0), 8'h01);
    rxCtlEn = 1;
    n0 = nPar;
    snd(8'hf0);
    snd(8'h43);
    msg3(8'h13, 8'h55, 8'hf7);
    chk(8'(nPar - n0), 8'h01);
    chk(parRxByte, 8'h55);
    rxParEn = 0;
    snd(8'hf0);
    snd(8'h43);
    msg3(8'h13, 8'h56, 8'hf7);
    chk(8'(nPar - n0), 8'h01);
    rxParEn = 1;
    pout(8'h5a);
    txq('{8'h5a});
    txParEn = 0;
    pout(8'h5b);
    repeat (20) @(negedge clk_sys);
    chk(8'(far.got.size()), 8'h00);
    txParEn = 1;
    $display("test control done");
  endtask

  task t_table;
    tblAddr = 7'h05;
    tblScene = 7'h09;
    tblEn = 1;
    pulse(tblWr);
    chk(tblRdData, 8'h89);
    pc(4'h3, 7'h05, 1, 7'h09);
    pulse(tblUndo);
    chk(tblRdData, 8'h86);
    tblEn = 0;
    pulse(tblWr);
    pc(4'h3, 7'h05, 0, 7'h00);
    pulse(tblReset);
    chk(tblRdData, 8'h86);
    pulse(tblUndo);
    chk(tblRdData, 8'h09);
    $display("test table done");
  endtask

  // Categories 6 and 7 carry one frame with item 0
  task t_bulk;
    logic [7:0] q[$];
    for (int c = 0; c < 8; c++)
    begin
      bulkCmd = msr_bcmd_e'(c[1:0]);
      bulkCat = msr_cat_e'(c[2:0]);
      bulkItem = 8'h10 + 8'(c);
      pulse(bulkGo);
      for (int i = 0; i < ((c[1] && c < 6) ? 3 : 1); i++)
      begin
        q = '{8'hf0, 8'h20 | 8'(c % 4), 8'(c),
              c[1] ? 8'(i) : (c < 6 ? 8'h10 + 8'(c) : 8'h00), 8'hf7};
        txq(q);
      end
      wst(MSR_B_DONE);
    end
    $display("test bulk done");
  endtask

  task t_abort;
    slow = 1;
    bulkCmd = MSR_C_DUMPALL;
    bulkCat = MSR_K_SCENE;
    bulkGo = 1;
    @(negedge clk_sys);
    bulkGo = 0;
    chk(8'(bulkStatus), 8'(MSR_B_SEND));
    repeat (6) @(negedge clk_sys);
    pulse(bulkAbort);
    wst(MSR_B_ABORT);
    repeat (40) @(negedge clk_sys);
    txq('{8'hf0, 8'h22, 8'h00, 8'h00, 8'hf7});
    chk(8'(far.got.size()), 8'h00);
    chk(bulkItemNow, 8'h00);
    far.got.delete();
    slow = 0;
    $display("test abort done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst = 0;
    repeat (2) @(negedge clk_sys);
    t_recall;
    t_chan;
    t_ctl;
    t_table;
    t_bulk;
    t_abort;
    conclude;
  end
endmodule
`default_nettype wire
